// file: pllrf_pkg.sv
package pllrf_pkg;

  // data path widths
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 8;
  localparam int R_W    = 14;
  localparam int A_W    = 6;
  localparam int B_W    = 13;
  localparam int PRES_W = 3;
  localparam int PS_W   = 6;

  // register offsets
  localparam logic [7:0] OFF_A_COUNT  = 8'h04;
  localparam logic [7:0] OFF_B_UPPER  = 8'h05;
  localparam logic [7:0] OFF_B_LOWER  = 8'h06;
  localparam logic [7:0] OFF_STATUS   = 8'h07;
  localparam logic [7:0] OFF_CNT_RST  = 8'h09;
  localparam logic [7:0] OFF_PRESCALE = 8'h0A;
  localparam logic [7:0] OFF_R_UPPER  = 8'h0B;
  localparam logic [7:0] OFF_R_LOWER  = 8'h0C;
  localparam logic [7:0] OFF_IN_SEL   = 8'h45;

  // field positions
  localparam int CNT_RST_ALL_BIT = 0;
  localparam int CNT_RST_AB_BIT  = 1;
  localparam int PRES_LSB        = 2;
  localparam int PRES_MSB        = 4;
  localparam int B_BYPASS_BIT    = 6;
  localparam int IN_SEL_BIT      = 0;

  // reset values
  localparam logic [R_W-1:0]    RST_R_DIV   = 14'h0000;
  localparam logic [A_W-1:0]    RST_A_COUNT = 6'h00;
  localparam logic [B_W-1:0]    RST_B_COUNT = 13'h0000;
  localparam logic [PRES_W-1:0] RST_PRES    = 3'h0;
  localparam logic              RST_BYPASS  = 1'h0;
  localparam logic [1:0]        RST_CNT_RST = 2'h0;
  localparam logic              RST_IN_SEL  = 1'h1;

  // prescaler field encodings
  localparam logic [PRES_W-1:0] PRES_FD1  = 3'h0;
  localparam logic [PRES_W-1:0] PRES_FD2  = 3'h1;
  localparam logic [PRES_W-1:0] PRES_DM2  = 3'h2;
  localparam logic [PRES_W-1:0] PRES_DM4  = 3'h3;
  localparam logic [PRES_W-1:0] PRES_DM8  = 3'h4;
  localparam logic [PRES_W-1:0] PRES_DM16 = 3'h5;
  localparam logic [PRES_W-1:0] PRES_DM32 = 3'h6;
  localparam logic [PRES_W-1:0] PRES_FD3  = 3'h7;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [BUS_AW-1:0] addr;
    logic [BUS_DW-1:0] wdata;
  } pllrf_bus_req_t;

endpackage

// file: pllrf_edge_sync.sv
`timescale 1ns/1ps
module pllrf_edge_sync
  import pllrf_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // pin side
  input  wire logic pinIn,
  // synchronised side
  output logic      level,
  output logic      rise
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;

  // stage1 feeds stage2 only; edges are judged on the settled stages
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
    end
    else
    begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  assign level = stage2_q;
  assign rise  = stage2_q & ~stage3_q;

endmodule

// file: pllrf_counter.sv
`timescale 1ns/1ps
module pllrf_counter
  import pllrf_pkg::*;
#(
  parameter int W = 14
)
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // count control
  input  wire logic         tick,
  input  wire logic         clr,
  input  wire logic [W-1:0] divVal,
  // results
  output logic              wrapNow,
  output logic              pulseOut,
  output logic [W-1:0]      curVal
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cur_q;
  logic         pulse_q;
  logic         atTerm;

  // a period value of zero behaves as one
  assign atTerm  = (cur_q == '0) || (cnt_q >= cur_q - W'(1));
  assign wrapNow = tick && atTerm && !clr;

  // new divide value is latched at a period boundary or while clr is held
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cnt_q   <= '0;
      cur_q   <= '0;
      pulse_q <= 1'b0;
    end
    else
    begin
      pulse_q <= wrapNow;
      if (clr)
      begin
        cnt_q <= '0;
        cur_q <= divVal;
      end
      else if (tick)
      begin
        cnt_q <= atTerm ? '0 : cnt_q + W'(1);
        cur_q <= atTerm ? divVal : cur_q;
      end
    end
  end

  assign pulseOut = pulse_q;
  assign curVal   = cur_q;

endmodule

// file: pllrf_dividers.sv
`timescale 1ns/1ps
// Summary of operation
// - reference input divided by 14-bit value 1..16383; zero divides by one
// - reference divider output feeds one phase detector input
// - reference value split: upper six bits at 0x0B, lower eight at 0x0C
// - feedback divider: 3-bit prescaler select, 6-bit A, 13-bit B counter
// - prescaler codes: fixed 1,2,3 and dual-modulus 2/3 up to 32/33
// - fixed-divide prescaler ignores A; B may need bypass
// - B bypass divides by one, honoured only with fixed-divide prescaler
// - bit 6 of prescaler register set to one bypasses B
// - B resets to zero, invalid; software must reprogram after reset
// - separate reset control for A and B counters, mainly for test
// - bit 0 of counter reset register clears R, A and B together
// - only feedback clock input drives feedback divider
// - distribution takes auxiliary input by default, feedback input when bit cleared
// - detector compares R output with feedback output, ratio B times P plus A
module pllrf_dividers
  import pllrf_pkg::*;
(
  // clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  // register port
  input  wire pllrf_bus_req_t busReq,
  output logic [BUS_DW-1:0]   rdData,
  // clock pins
  input  wire logic           refClkIn,
  input  wire logic           fbClkIn,
  input  wire logic           auxClkIn,
  // divider and detector results
  output logic                refDivOut,
  output logic                fbDivOut,
  output logic                pfdUp,
  output logic                pfdDown,
  output logic                distClkOut
);

  // prescaler modulus for a select code; upper picks P+1 in dual-modulus
  function automatic logic [PS_W-1:0] presModulus(input logic [PRES_W-1:0] sel,
                                                  input logic upper);
    logic [PS_W-1:0] m;
    m = 6'h01;
    case (sel)
      PRES_FD1:  m = 6'h01;
      PRES_FD2:  m = 6'h02;
      PRES_FD3:  m = 6'h03;
      PRES_DM2:  m = upper ? 6'h03 : 6'h02;
      PRES_DM4:  m = upper ? 6'h05 : 6'h04;
      PRES_DM8:  m = upper ? 6'h09 : 6'h08;
      PRES_DM16: m = upper ? 6'h11 : 6'h10;
      PRES_DM32: m = upper ? 6'h21 : 6'h20;
      default:   m = 6'h01;
    endcase
    return m;
  endfunction

  function automatic logic presFixed(input logic [PRES_W-1:0] sel);
    return (sel == PRES_FD1) || (sel == PRES_FD2) || (sel == PRES_FD3);
  endfunction

  // control registers
  logic [A_W-1:0]    regA_q;
  logic [B_W-1:0]    regB_q;
  logic [R_W-1:0]    regR_q;
  logic [PRES_W-1:0] presSel_q;
  logic              bBypass_q;
  logic [1:0]        cntRst_q;
  logic              inSel_q;
  logic [BUS_DW-1:0] rdData_q;

  // datapath state
  logic [PS_W-1:0]   psCnt_q;
  logic [A_W-1:0]    aRem_q;
  logic              fbPulse_q;
  logic              pfdUp_q;
  logic              pfdDown_q;
  logic              distClk_q;

  // synchronised pins
  logic refLvl;
  logic refTick;
  logic fbLvl;
  logic fbTick;
  logic auxLvl;
  logic auxTick;

  pllrf_edge_sync u_refSync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   (refClkIn),
    .level   (refLvl),
    .rise    (refTick)
  );

  pllrf_edge_sync u_fbSync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   (fbClkIn),
    .level   (fbLvl),
    .rise    (fbTick)
  );

  pllrf_edge_sync u_auxSync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   (auxClkIn),
    .level   (auxLvl),
    .rise    ()
  );

  // write decode
  wire wrA     = busReq.wr && (busReq.addr == OFF_A_COUNT);
  wire wrBHi   = busReq.wr && (busReq.addr == OFF_B_UPPER);
  wire wrBLo   = busReq.wr && (busReq.addr == OFF_B_LOWER);
  wire wrCnt   = busReq.wr && (busReq.addr == OFF_CNT_RST);
  wire wrPres  = busReq.wr && (busReq.addr == OFF_PRESCALE);
  wire wrRHi   = busReq.wr && (busReq.addr == OFF_R_UPPER);
  wire wrRLo   = busReq.wr && (busReq.addr == OFF_R_LOWER);
  wire wrInSel = busReq.wr && (busReq.addr == OFF_IN_SEL);

  // counter resets are levels held for as long as the bits stay set
  wire allRst = cntRst_q[CNT_RST_ALL_BIT];
  wire abRst  = allRst | cntRst_q[CNT_RST_AB_BIT];

  // feedback chain state
  wire             fixedMode    = presFixed(presSel_q);
  wire             bypassActive = bBypass_q && fixedMode;
  wire             useUpper     = !fixedMode && (aRem_q != 6'h00);
  wire [PS_W-1:0]  psMod        = presModulus(presSel_q, useUpper);
  wire             psWrap       = fbTick && !abRst && (psCnt_q >= psMod - 6'h01);
  wire             bWrap;
  wire [B_W-1:0]   bCur;
  wire [R_W-1:0]   refCur;
  wire             refWrap;
  wire             refPulse;

  // reference divider
  pllrf_counter #(.W(R_W)) u_refDiv (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .tick     (refTick),
    .clr      (allRst),
    .divVal   (regR_q),
    .wrapNow  (refWrap),
    .pulseOut (refPulse),
    .curVal   (refCur)
  );

  // B counter, ticked by prescaler output
  pllrf_counter #(.W(B_W)) u_bDiv (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .tick     (psWrap),
    .clr      (abRst),
    .divVal   (regB_q),
    .wrapNow  (bWrap),
    .pulseOut (),
    .curVal   (bCur)
  );

  // prescaler and A counter
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || abRst)
    begin
      psCnt_q <= '0;
      aRem_q  <= '0;
    end
    else if (fbTick)
    begin
      psCnt_q <= psWrap ? '0 : psCnt_q + 6'h01;
      if (psWrap)
        aRem_q <= bWrap ? regA_q : (aRem_q != 6'h00 ? aRem_q - 6'h01 : aRem_q);
    end
  end

  // feedback output: prescaler alone when bypassed, else B terminal count
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      fbPulse_q <= 1'b0;
    else
      fbPulse_q <= bypassActive ? psWrap : bWrap;
  end

  // phase/frequency detector; both flags set means coincidence, so both drop
  wire upNext = pfdUp_q | refPulse;
  wire dnNext = pfdDown_q | fbPulse_q;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || (upNext && dnNext))
    begin
      pfdUp_q   <= 1'b0;
      pfdDown_q <= 1'b0;
    end
    else
    begin
      pfdUp_q   <= upNext;
      pfdDown_q <= dnNext;
    end
  end

  // distribution mux; a sampled copy only, so fine edge timing is lost here
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      distClk_q <= 1'b0;
    else
      distClk_q <= inSel_q ? auxLvl : fbLvl;
  end

  // register writes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      regA_q    <= RST_A_COUNT;
      regB_q    <= RST_B_COUNT;
      regR_q    <= RST_R_DIV;
      presSel_q <= RST_PRES;
      bBypass_q <= RST_BYPASS;
      cntRst_q  <= RST_CNT_RST;
      inSel_q   <= RST_IN_SEL;
    end
    else
    begin
      if (wrA)     regA_q        <= busReq.wdata[A_W-1:0];
      if (wrBHi)   regB_q[12:8]  <= busReq.wdata[4:0];
      if (wrBLo)   regB_q[7:0]   <= busReq.wdata;
      if (wrRHi)   regR_q[13:8]  <= busReq.wdata[5:0];
      if (wrRLo)   regR_q[7:0]   <= busReq.wdata;
      if (wrCnt)   cntRst_q      <= busReq.wdata[1:0];
      if (wrInSel) inSel_q       <= busReq.wdata[IN_SEL_BIT];
      if (wrPres)
      begin
        presSel_q <= busReq.wdata[PRES_MSB:PRES_LSB];
        bBypass_q <= busReq.wdata[B_BYPASS_BIT];
      end
    end
  end

  // read mux; unmapped offsets read as zero
  wire [BUS_DW-1:0] rdMux =
    (busReq.addr == OFF_A_COUNT)  ? {2'h0, regA_q} :
    (busReq.addr == OFF_B_UPPER)  ? {3'h0, regB_q[12:8]} :
    (busReq.addr == OFF_B_LOWER)  ? regB_q[7:0] :
    (busReq.addr == OFF_STATUS)   ? {4'h0, bypassActive, fixedMode, pfdDown_q, pfdUp_q} :
    (busReq.addr == OFF_CNT_RST)  ? {6'h00, cntRst_q} :
    (busReq.addr == OFF_PRESCALE) ? {1'h0, bBypass_q, 1'h0, presSel_q, 2'h0} :
    (busReq.addr == OFF_R_UPPER)  ? {2'h0, regR_q[13:8]} :
    (busReq.addr == OFF_R_LOWER)  ? regR_q[7:0] :
    (busReq.addr == OFF_IN_SEL)   ? {7'h00, inSel_q} :
    8'h00;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rdData_q <= 8'h00;
    else
      rdData_q <= busReq.rd ? rdMux : 8'h00;
  end

  assign rdData     = rdData_q;
  assign refDivOut  = refPulse;
  assign fbDivOut   = fbPulse_q;
  assign pfdUp      = pfdUp_q;
  assign pfdDown    = pfdDown_q;
  assign distClkOut = distClk_q;

  // checks
  property p_refZero;
    @(posedge clk_sys) disable iff (!rst_n)
    (refTick && !allRst && refCur == 14'h0000) |=> refDivOut;
  endproperty
  a_refZero: assert property (p_refZero) else $error("zero R did not divide by one");

  property p_pfdUp;
    @(posedge clk_sys) disable iff (!rst_n)
    (refDivOut && !fbDivOut && !pfdDown_q) |=> (pfdUp_q && !pfdDown_q);
  endproperty
  a_pfdUp: assert property (p_pfdUp) else $error("ref pulse did not raise up flag");

  property p_rUpper;
    @(posedge clk_sys) disable iff (!rst_n)
    (busReq.wr && busReq.addr == OFF_R_UPPER) |=> (regR_q[13:8] == $past(busReq.wdata[5:0]));
  endproperty
  a_rUpper: assert property (p_rUpper) else $error("R upper bits not stored");

  property p_fd1;
    @(posedge clk_sys) disable iff (!rst_n)
    (fbTick && !abRst && presSel_q == PRES_FD1) |-> psWrap;
  endproperty
  a_fd1: assert property (p_fd1) else $error("fixed divide by one missed an edge");

  property p_fixedIgnoresA;
    @(posedge clk_sys) disable iff (!rst_n)
    (presSel_q == PRES_FD3) |-> (psMod == 6'h03);
  endproperty
  a_fixedIgnoresA: assert property (p_fixedIgnoresA) else $error("A altered fixed divide");

  property p_bypassOut;
    @(posedge clk_sys) disable iff (!rst_n)
    (bypassActive && psWrap) |=> fbDivOut;
  endproperty
  a_bypassOut: assert property (p_bypassOut) else $error("bypassed B did not pass prescaler");

  property p_noBypassDm;
    @(posedge clk_sys) disable iff (!rst_n)
    (!fixedMode && !bWrap) |=> !fbDivOut;
  endproperty
  a_noBypassDm: assert property (p_noBypassDm) else $error("bypass honoured in dual-modulus");

  property p_bypassBit;
    @(posedge clk_sys) disable iff (!rst_n)
    (busReq.wr && busReq.addr == OFF_PRESCALE) |=> (bBypass_q == $past(busReq.wdata[6]));
  endproperty
  a_bypassBit: assert property (p_bypassBit) else $error("bypass bit not stored");

  property p_bReset;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> (regB_q == 13'h0000);
  endproperty
  a_bReset: assert property (p_bReset) else $error("B not zero after reset");

  property p_commonReset;
    @(posedge clk_sys) disable iff (!rst_n)
    allRst |=> (!refDivOut && !fbDivOut);
  endproperty
  a_commonReset: assert property (p_commonReset) else $error("counters ran under reset");

  property p_distFb;
    @(posedge clk_sys) disable iff (!rst_n)
    !inSel_q |=> (distClkOut == $past(fbLvl));
  endproperty
  a_distFb: assert property (p_distFb) else $error("feedback input not distributed");

  property p_dmUpper;
    @(posedge clk_sys) disable iff (!rst_n)
    (presSel_q == PRES_DM4) |-> (psMod == ((aRem_q != 6'h00) ? 6'h05 : 6'h04));
  endproperty
  a_dmUpper: assert property (p_dmUpper) else $error("wrong dual-modulus selection");

  property p_readBack;
    @(posedge clk_sys) disable iff (!rst_n)
    (busReq.rd && busReq.addr == OFF_R_LOWER) |=> (rdData == $past(regR_q[7:0]));
  endproperty
  a_readBack: assert property (p_readBack) else $error("R lower read back wrong");

endmodule

// file: pllrf_osc_model.sv
`timescale 1ns/1ps
// free-running reference, oscillator and auxiliary sources
module pllrf_osc_model
(
  // control
  input  wire logic slow,
  // clock pins
  output logic      refClk,
  output logic      fbClk,
  output logic      auxClk
);
  // half periods sit off the 5 ns grid so edges drift against clk_sys
  initial
  begin
    refClk = 1'b0;
    forever #12.0 refClk = ~refClk;
  end
  // slow mode stretches the oscillator, ratios must not change
  initial
  begin
    fbClk = 1'b0;
    forever #(slow ? 23.0 : 11.0) fbClk = ~fbClk;
  end
  initial
  begin
    auxClk = 1'b0;
    forever #17.0 auxClk = ~auxClk;
  end
endmodule

// file: tb_pllrf_dividers.sv
`timescale 1ns/1ps
module tb_pllrf_dividers
  import pllrf_pkg::*;
();
  logic              clk_sys, rst_n, slow;
  pllrf_bus_req_t    busReq;
  logic [BUS_DW-1:0] rdData, d;
  logic              refClk, fbClk, auxClk, refDivOut, fbDivOut;
  logic              pfdUp, pfdDown, distClkOut;
  logic              refQ, fbQ, auxQ, distQ, prR, prF, prU, prD, mon;
  logic [31:0]       lfsrQ;
  int                errCount = 0, checks = 0, i, a, b, r, f, dd, ax, fx;
  int                refE = 0, fbE = 0, auxE = 0, distE = 0, refP = 0, fbP = 0;
  logic [7:0]        tAddr [8] = '{8'h04, 8'h05, 8'h06, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h45};
  logic [7:0]        tMask [8] = '{8'h3F, 8'h1F, 8'hFF, 8'h03, 8'h5C, 8'h3F, 8'hFF, 8'h01};
  int                rv [4] = '{0, 1, 5, 259};

  pllrf_osc_model u_osc (.slow(slow), .refClk(refClk), .fbClk(fbClk), .auxClk(auxClk));

  pllrf_dividers u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
    .refClkIn(refClk), .fbClkIn(fbClk), .auxClkIn(auxClk), .refDivOut(refDivOut),
    .fbDivOut(fbDivOut), .pfdUp(pfdUp), .pfdDown(pfdDown), .distClkOut(distClkOut));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int expFb(input logic [2:0] c, input int a, input int b, input bit byp);
    int p;
    p = (c == PRES_FD1) ? 1 : (c == PRES_FD2) ? 2 : (c == PRES_FD3) ? 3 : (2 << (c - 3'h2));
    if (c == PRES_FD1 || c == PRES_FD2 || c == PRES_FD3)
      return byp ? p : p * b;
    return p * b + a;
  endfunction

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", checks, errCount);
    if (errCount == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // pin edges and pulses counted on clk_sys so latency cancels in differences
  always @(posedge clk_sys)
  begin
    refQ <= refClk;
    fbQ <= fbClk;
    auxQ <= auxClk;
    distQ <= distClkOut;
    refE <= refE + int'(refClk & ~refQ);
    fbE <= fbE + int'(fbClk & ~fbQ);
    auxE <= auxE + int'(auxClk & ~auxQ);
    distE <= distE + int'(distClkOut & ~distQ);
    refP <= refP + int'(refDivOut === 1'b1);
    fbP <= fbP + int'(fbDivOut === 1'b1);
    {prR, prF, prU, prD} <= {refDivOut, fbDivOut, pfdUp, pfdDown};
    mon <= rst_n;
    if (mon === 1'b1 && rst_n === 1'b1 && (prR === 1'b1 || prF === 1'b1))
    begin
      check(pfdUp, prR && !prF && !prD);
      check(pfdDown, prF && !prR && !prU);
    end
  end

  task automatic busWr(input logic [7:0] ad, input logic [7:0] wd);
    @(posedge clk_sys);
    busReq <= '{1'b1, 1'b0, ad, wd};
    @(posedge clk_sys);
    busReq.wr <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    busReq <= '{1'b0, 1'b1, ad, 8'h00};
    @(posedge clk_sys);
    busReq.rd <= 1'b0;
    #1 check(rdData & m, e & m);
  endtask

  task automatic waitPulse(input bit fb);
    int k;
    for (k = 0; k < 4000; k++)
    begin
      @(posedge clk_sys);
      if ((fb ? fbDivOut : refDivOut) === 1'b1)
        return;
    end
    errCount++;
    end_of_test();
  endtask

  // skip two periods so a freshly written value is in force
  task automatic measure(input bit fb, input int exp);
    int s;
    waitPulse(fb);
    waitPulse(fb);
    #1 s = fb ? fbE : refE;
    waitPulse(fb);
    #1 check(fb ? fbE - s : refE - s, exp);
  endtask

  // settle two cycles so a pulse launched by the control write is not counted
  task automatic window();
    int r0, f0, d0, a0, b0;
    repeat (2) @(posedge clk_sys);
    #1 r0 = refP;
    f0 = fbP;
    d0 = distE;
    a0 = auxE;
    b0 = fbE;
    repeat (400) @(posedge clk_sys);
    #1 r = refP - r0;
    f = fbP - f0;
    dd = distE - d0;
    ax = auxE - a0;
    fx = fbE - b0;
  endtask

  task automatic doReset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  // a long period left from random values would outlast the wait bound,
  // so pulse the common clear to latch the freshly written divide values
  task automatic clrCnt();
    busWr(8'h09, 8'h01);
    busWr(8'h09, 8'h00);
  endtask

  initial
  begin
    busReq = '0;
    rst_n = 1'b0;
    slow = 1'b0;
    lfsrQ = 32'h1a05;
    doReset();
    for (i = 0; i < 8; i++)
      rdChk(tAddr[i], tMask[i], (i == 7) ? 8'h01 : 8'h00);
    for (i = 0; i < 8; i++)
    begin
      lfsrQ = lfsrNext(lfsrQ);
      busWr(tAddr[i], lfsrQ[7:0]);
      rdChk(tAddr[i], tMask[i], lfsrQ[7:0]);
    end
    busWr(8'h20, 8'h5A);
    rdChk(8'h20, 8'hFF, 8'h00);
    busWr(8'h09, 8'h00);
    busWr(8'h45, 8'h01);
    for (i = 0; i < 5; i++)
    begin
      lfsrQ = lfsrNext(lfsrQ);
      r = (i < 4) ? rv[i] : 2 + int'(lfsrQ[2:0]);
      busWr(8'h0B, 8'(r >> 8));
      busWr(8'h0C, 8'(r));
      clrCnt();
      measure(1'b0, (r == 0) ? 1 : r);
    end
    busWr(8'h04, 8'h01);
    busWr(8'h05, 8'h00);
    busWr(8'h06, 8'h03);
    clrCnt();
    for (i = 0; i < 8; i++)
    begin
      busWr(8'h0A, 8'(i << 2));
      measure(1'b1, expFb(3'(i), 1, 3, 1'b0));
    end
    lfsrQ = lfsrNext(lfsrQ);
    a = int'(lfsrQ[1:0]);
    b = 3 + int'(lfsrQ[4:2]);
    busWr(8'h04, 8'(a));
    busWr(8'h06, 8'(b));
    busWr(8'h0A, 8'h0C);
    measure(1'b1, expFb(PRES_DM4, a, b, 1'b0));
    busWr(8'h0A, 8'h44);
    measure(1'b1, expFb(PRES_FD2, a, b, 1'b1));
    rdChk(8'h07, 8'h0C, 8'h0C);
    busWr(8'h0A, 8'h40);
    measure(1'b1, expFb(PRES_FD1, a, b, 1'b1));
    busWr(8'h0A, 8'h48);
    slow = 1'b1;
    measure(1'b1, expFb(PRES_DM2, a, b, 1'b0));
    rdChk(8'h07, 8'h0C, 8'h00);
    slow = 1'b0;
    busWr(8'h09, 8'h01);
    window();
    check(r + f, 0);
    busWr(8'h09, 8'h02);
    window();
    check(f, 0);
    check(r > 0, 1);
    busWr(8'h09, 8'h00);
    window();
    check(dd >= ax - 1 && dd <= ax + 1, 1);
    busWr(8'h45, 8'h00);
    window();
    check(dd >= fx - 1 && dd <= fx + 1, 1);
    doReset();
    rdChk(8'h06, 8'hFF, 8'h00);
    rdChk(8'h45, 8'h01, 8'h01);
    end_of_test();
  end
endmodule
